// ---- calu_consts.vh ----
// operation codes and flag positions for the arithmetic, logic and shift unit
`ifndef CALU_CONSTS_VH
`define CALU_CONSTS_VH

// operation select codes
`define CALU_OP_ADD         5'h00
`define CALU_OP_SUB         5'h01
`define CALU_OP_ADD_CARRY   5'h02
`define CALU_OP_SUB_BORROW  5'h03
`define CALU_OP_INC         5'h04
`define CALU_OP_DEC         5'h05
`define CALU_OP_ADDS        5'h06
`define CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD        5'h07
`define CALU_OP_DADJ_ADD    5'h08
`define CALU_OP_DADJ_SUB    5'h09
`define CALU_OP_MULU        5'h0A
`define CALU_OP_DIVU        5'h0B
`define CALU_OP_CMP         5'h0C
`define CALU_OP_NEG         5'h0D
`define CALU_OP_AND         5'h0E
`define CALU_OP_OR          5'h0F
`define CALU_OP_XOR         5'h10
`define CALU_OP_NOT         5'h11
`define CALU_OP_ASHL        5'h12
`define CALU_OP_ASHR        5'h13
`define CALU_OP_LSHL        5'h14
`define CALU_OP_LSHR        5'h15
`define CALU_OP_ROTATE_LEFT        5'h16
`define CALU_OP_ROTATE_RIGHT        5'h17
`define CALU_OP_ROTATE_LEFT_THROUGH_CARRY       5'h18
`define CALU_OP_ROTATE_RIGHT_THROUGH_CARRY       5'h19

// flag bit positions in the flag vector {h,n,z,v,c}
`define CALU_FLG_C          0
`define CALU_FLG_V          1
`define CALU_FLG_Z          2
`define CALU_FLG_N          3
`define CALU_FLG_H          4
`define CALU_FLAGS_RST      5'h00

// divider iteration count (one quotient bit per cycle)
`define CALU_DIV_STEPS      4'h8

`endif

// ---- calu_core.v ----
// arithmetic, logic and shift datapath of the cpu execution stage
`timescale 1ns/1ps
`include "calu_consts.vh"
module calu_core #(
   parameter DW = 8
) (
   clock,
   nrst,
   ce,
   op_valid,
   op_code,
   op_word,
   op_use_imm,
   op_imm_two,
   dst_val,
   src_val,
   imm_val,
   flags_in,
   op_ready,
   res_valid,
   res_data,
   res_write,
   res_word,
   flags_out,
   op_illegal
);
   input  wire            clock;
   input  wire            nrst;
   input  wire            ce;
   input  wire            op_valid;   // operation present this cycle
   input  wire [4:0]      op_code;
   input  wire            op_word;    // 1 = word width
   input  wire            op_use_imm; // second operand from immediate
   input  wire            op_imm_two; // word constant is 2 instead of 1
   input  wire [2*DW-1:0] dst_val;
   input  wire [2*DW-1:0] src_val;
   input  wire [DW-1:0]   imm_val;
   input  wire [4:0]      flags_in;   // current condition_flags_register bits
   output wire            op_ready;
   output reg             res_valid;
   output reg  [2*DW-1:0] res_data;
   output reg             res_write;  // destination must be written
   output reg             res_word;
   output reg  [4:0]      flags_out;
   output reg             op_illegal;

   reg  [2*DW-1:0] r_nxt;
   reg  [4:0]      f_nxt;
   reg             wr_nxt;
   reg             wd_nxt;
   reg             bad_nxt;
   reg  [DW-1:0]   b_op;
   reg  [DW:0]     bsum;
   reg  [2*DW:0]   wsum;
   reg  [DW-1:0]   corr;
   reg             hc;
   wire            c_in;
   wire            div_start;
   wire            div_busy;
   wire            div_done;
   wire [DW-1:0]   div_q;
   wire [DW-1:0]   div_r;
   wire            div_z;
   wire            is_div;

   assign c_in      = flags_in[`CALU_FLG_C];
   assign is_div    = (op_code == `CALU_OP_DIVU);
   assign div_start = op_valid && is_div && !div_busy && !div_done;
   // decoder stalls while the divider iterates
   assign op_ready  = !(op_valid && is_div) || div_done;

   ////////////////////////////////////////////////////////////////////////
   // byte add or subtract with carry in; returns {h, c, v, result}
   function [DW+2:0] badd;
      input [DW-1:0] a;
      input [DW-1:0] b;
      input          sub;
      input          cin;
      reg   [DW-1:0] bx;
      reg   [DW:0]   s;
      reg   [4:0]    lo;
      begin
         bx   = sub ? ~b : b;
         s    = {1'b0, a} + {1'b0, bx} + {{DW{1'b0}}, (sub ? ~cin : cin)};
         lo   = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, (sub ? ~cin : cin)};
         badd = {lo[4] ^ sub, s[DW] ^ sub,
                 (a[DW-1] == bx[DW-1]) && (s[DW-1] != a[DW-1]), s[DW-1:0]};
      end
   endfunction

   // word add or subtract, no carry in; returns {h, c, v, result}
   function [2*DW+2:0] wadd;
      input [2*DW-1:0] a;
      input [2*DW-1:0] b;
      input            sub;
      reg   [2*DW-1:0] bx;
      reg   [2*DW:0]   s;
      reg   [12:0]     lo;
      begin
         bx   = sub ? ~b : b;
         s    = {1'b0, a} + {1'b0, bx} + {{(2*DW){1'b0}}, sub};
         lo   = {1'b0, a[11:0]} + {1'b0, bx[11:0]} + {12'h000, sub};
         wadd = {lo[12] ^ sub, s[2*DW] ^ sub,
                 (a[2*DW-1] == bx[2*DW-1]) && (s[2*DW-1] != a[2*DW-1]), s[2*DW-1:0]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // operation select and flag formation
   always @* begin
      r_nxt   = dst_val;
      f_nxt   = flags_in;
      wr_nxt  = 1'b1;
      wd_nxt  = 1'b0;
      bad_nxt = 1'b0;
      b_op    = op_use_imm ? imm_val : src_val[DW-1:0];
      bsum    = {(DW+1){1'b0}};
      wsum    = {(2*DW+1){1'b0}};
      corr    = {DW{1'b0}};
      hc      = 1'b0;
      case (op_code)
         `CALU_OP_ADD, `CALU_OP_SUB, `CALU_OP_CMP: begin
            // subtract has no immediate form; word width registers only
            if ((op_code == `CALU_OP_SUB && op_use_imm) || (op_word && op_use_imm))
               bad_nxt = 1'b1;
            wr_nxt = (op_code != `CALU_OP_CMP);
            if (op_word) begin
               wd_nxt = 1'b1;
               {f_nxt[`CALU_FLG_H], f_nxt[`CALU_FLG_C], f_nxt[`CALU_FLG_V], r_nxt} =
                  wadd(dst_val, src_val, op_code != `CALU_OP_ADD);
               f_nxt[`CALU_FLG_N] = r_nxt[2*DW-1];
               f_nxt[`CALU_FLG_Z] = (r_nxt == {(2*DW){1'b0}});
            end else begin
               {f_nxt[`CALU_FLG_H], f_nxt[`CALU_FLG_C], f_nxt[`CALU_FLG_V], r_nxt[DW-1:0]} =
                  badd(dst_val[DW-1:0], b_op, op_code != `CALU_OP_ADD, 1'b0);
            end
         end
         `CALU_OP_ADD_CARRY, `CALU_OP_SUB_BORROW: begin
            {f_nxt[`CALU_FLG_H], f_nxt[`CALU_FLG_C], f_nxt[`CALU_FLG_V], r_nxt[DW-1:0]} =
               badd(dst_val[DW-1:0], b_op, op_code == `CALU_OP_SUB_BORROW, c_in);
            // zero only stays set across a multi-byte chain
            if (r_nxt[DW-1:0] != {DW{1'b0}})
               f_nxt[`CALU_FLG_Z] = 1'b0;
         end
         `CALU_OP_INC, `CALU_OP_DEC: begin
            // carry untouched so counters can sit inside carry chains
            {hc, bsum[0], f_nxt[`CALU_FLG_V], r_nxt[DW-1:0]} =
               badd(dst_val[DW-1:0], {{(DW-1){1'b0}}, 1'b1}, op_code == `CALU_OP_DEC, 1'b0);
         end
         `CALU_OP_ADDS, `CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD: begin
            wd_nxt = 1'b1;
            // address arithmetic: flags are left alone
            wsum = {1'b0, dst_val} + (op_code == `CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD ?
                   (op_imm_two ? {(2*DW+1){1'b1}} - {{(2*DW-1){1'b0}}, 2'b01}
                               : {(2*DW+1){1'b1}})
                 : {{(2*DW-1){1'b0}}, op_imm_two, !op_imm_two});
            r_nxt = wsum[2*DW-1:0];
         end
         `CALU_OP_DADJ_ADD, `CALU_OP_DADJ_SUB: begin
            // correction from carry and half carry, plus digit ranges for the add adjust only
            if (op_code == `CALU_OP_DADJ_ADD) begin
               if (c_in || dst_val[DW-1:0] > 8'h99) begin
                  corr[7:4] = 4'h6;
                  f_nxt[`CALU_FLG_C] = 1'b1;
               end
               if (flags_in[`CALU_FLG_H] || dst_val[3:0] > 4'h9)
                  corr[3:0] = 4'h6;
               r_nxt[DW-1:0] = dst_val[DW-1:0] + corr;
            end else begin
               if (c_in)
                  corr[7:4] = 4'h6;
               if (flags_in[`CALU_FLG_H])
                  corr[3:0] = 4'h6;
               r_nxt[DW-1:0] = dst_val[DW-1:0] - corr;
            end
         end
         `CALU_OP_MULU: begin
            wd_nxt = 1'b1;
            r_nxt  = {{DW{1'b0}}, dst_val[DW-1:0]} * {{DW{1'b0}}, src_val[DW-1:0]};
         end
         `CALU_OP_DIVU: begin
            wd_nxt = 1'b1;
            r_nxt  = {div_r, div_q};
            f_nxt[`CALU_FLG_N] = div_q[DW-1];
            f_nxt[`CALU_FLG_Z] = div_z || (src_val[DW-1:0] == {DW{1'b0}});
         end
         `CALU_OP_NEG: begin
            {hc, f_nxt[`CALU_FLG_C], f_nxt[`CALU_FLG_V], r_nxt[DW-1:0]} =
               badd({DW{1'b0}}, dst_val[DW-1:0], 1'b1, 1'b0);
         end
         `CALU_OP_AND: r_nxt[DW-1:0] = dst_val[DW-1:0] & b_op;
         `CALU_OP_OR:  r_nxt[DW-1:0] = dst_val[DW-1:0] | b_op;
         `CALU_OP_XOR: r_nxt[DW-1:0] = dst_val[DW-1:0] ^ b_op;
         `CALU_OP_NOT: r_nxt[DW-1:0] = ~dst_val[DW-1:0];
         `CALU_OP_ASHL, `CALU_OP_LSHL: begin
            r_nxt[DW-1:0] = {dst_val[DW-2:0], 1'b0};
            f_nxt[`CALU_FLG_C] = dst_val[DW-1];
         end
         `CALU_OP_ASHR: begin
            r_nxt[DW-1:0] = {dst_val[DW-1], dst_val[DW-1:1]};
            f_nxt[`CALU_FLG_C] = dst_val[0];
         end
         `CALU_OP_LSHR: begin
            r_nxt[DW-1:0] = {1'b0, dst_val[DW-1:1]};
            f_nxt[`CALU_FLG_C] = dst_val[0];
         end
         `CALU_OP_ROTATE_LEFT: begin
            r_nxt[DW-1:0] = {dst_val[DW-2:0], dst_val[DW-1]};
            f_nxt[`CALU_FLG_C] = dst_val[DW-1];
         end
         `CALU_OP_ROTATE_RIGHT: begin
            r_nxt[DW-1:0] = {dst_val[0], dst_val[DW-1:1]};
            f_nxt[`CALU_FLG_C] = dst_val[0];
         end
         `CALU_OP_ROTATE_LEFT_THROUGH_CARRY: begin
            r_nxt[DW-1:0] = {dst_val[DW-2:0], c_in};
            f_nxt[`CALU_FLG_C] = dst_val[DW-1];
         end
         `CALU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
            r_nxt[DW-1:0] = {c_in, dst_val[DW-1:1]};
            f_nxt[`CALU_FLG_C] = dst_val[0];
         end
         default: begin
            bad_nxt = 1'b1;
            wr_nxt  = 1'b0;
         end
      endcase
      // common byte-result flags; word and special cases handled above
      if (!wd_nxt && op_code != `CALU_OP_ADD_CARRY && op_code != `CALU_OP_SUB_BORROW) begin
         f_nxt[`CALU_FLG_N] = r_nxt[DW-1];
         f_nxt[`CALU_FLG_Z] = (r_nxt[DW-1:0] == {DW{1'b0}});
      end else if (op_code == `CALU_OP_ADD_CARRY || op_code == `CALU_OP_SUB_BORROW) begin
         f_nxt[`CALU_FLG_N] = r_nxt[DW-1];
      end
      // logic and shift ops clear overflow; mulu/adds leave flags
      if (op_code >= `CALU_OP_AND && op_code <= `CALU_OP_ROTATE_RIGHT_THROUGH_CARRY) begin
         f_nxt[`CALU_FLG_V] = 1'b0;
         f_nxt[`CALU_FLG_H] = flags_in[`CALU_FLG_H];
      end
      if (op_code == `CALU_OP_ADDS || op_code == `CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD || op_code == `CALU_OP_MULU)
         f_nxt = flags_in;
      if (!wd_nxt)
         r_nxt[2*DW-1:DW] = dst_val[2*DW-1:DW];
      if (bad_nxt) begin
         wr_nxt = 1'b0;
         r_nxt  = dst_val;
         f_nxt  = flags_in; // refused operation changes nothing
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result register; divide completes a few cycles later
   always @(posedge clock) begin
      if (!nrst) begin
         res_valid  <= 1'b0;
         res_data   <= {(2*DW){1'b0}};
         res_write  <= 1'b0;
         res_word   <= 1'b0;
         flags_out  <= `CALU_FLAGS_RST;
         op_illegal <= 1'b0;
      end else if (ce) begin
         res_valid  <= op_valid && op_ready;
         res_write  <= op_valid && op_ready && wr_nxt;
         op_illegal <= op_valid && op_ready && bad_nxt;
         if (op_valid && op_ready) begin
            res_data  <= r_nxt;
            res_word  <= wd_nxt;
            flags_out <= f_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // iterative divider keeps the combinational path short
   calu_divider #(
      .DW (DW)
   ) u_div (
      .clock     (clock),
      .nrst      (nrst),
      .ce        (ce),
      .start     (div_start),
      .dividend  (dst_val),
      .divisor   (src_val[DW-1:0]),
      .busy      (div_busy),
      .done      (div_done),
      .quotient  (div_q),
      .remainder (div_r),
      .div_zero  (div_z)
   );
endmodule // calu_core

// ---- calu_core_sva.sv ----
// assertion checker on the ports of the arithmetic, logic and shift core
`timescale 1ns/1ps
`include "calu_consts.vh"
module calu_core_sva #(
   parameter DW = 8
) (
   input wire            clock,
   input wire            nrst,
   input wire            ce,
   input wire            op_valid,
   input wire [4:0]      op_code,
   input wire            op_word,
   input wire            op_use_imm,
   input wire            op_imm_two,
   input wire [2*DW-1:0] dst_val,
   input wire [2*DW-1:0] src_val,
   input wire [DW-1:0]   imm_val,
   input wire [4:0]      flags_in,
   input wire            op_ready,
   input wire            res_valid,
   input wire [2*DW-1:0] res_data,
   input wire            res_write,
   input wire            res_word,
   input wire [4:0]      flags_out,
   input wire            op_illegal
);
   ////////////////////////////////////////
   // op taken at an enabled edge with ready high
   wire          tk = ce && op_valid && op_ready;
   wire [DW-1:0] db = dst_val[DW-1:0];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // each taken op answers on the next edge
   property p_answer; tk |=> res_valid; endproperty
   a_answer: assert property (p_answer) else $error("taken op got no answer");
   property p_sub_imm; tk && op_code == `CALU_OP_SUB && op_use_imm |=> op_illegal && !res_write; endproperty
   a_sub_imm: assert property (p_sub_imm) else $error("subtract immediate not refused");
   property p_word_imm;
      tk && op_word && op_use_imm && (op_code == `CALU_OP_ADD || op_code == `CALU_OP_CMP) |=> op_illegal;
   endproperty
   a_word_imm: assert property (p_word_imm) else $error("word immediate not refused");
   // a refused op leaves flags and destination as they were
   property p_refuse;
      op_illegal |-> flags_out == $past(flags_in) && res_data == $past(dst_val) && !res_write;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused op changed state");
   property p_cmp; tk && op_code == `CALU_OP_CMP |=> res_valid && !res_write; endproperty
   a_cmp: assert property (p_cmp) else $error("compare wrote its result");
   property p_neg; tk && op_code == `CALU_OP_NEG |=> res_data[DW-1:0] == {DW{1'b0}} - $past(db); endproperty
   a_neg: assert property (p_neg) else $error("negate result wrong");
   property p_mul; tk && op_code == `CALU_OP_MULU |=> res_data == $past(db) * $past(src_val[DW-1:0]); endproperty
   a_mul: assert property (p_mul) else $error("product wrong");
   // only quotients that fit a byte are judged here
   property p_div;
      tk && op_code == `CALU_OP_DIVU && dst_val[2*DW-1:DW] < src_val[DW-1:0] |=>
         res_data[DW-1:0] == $past(dst_val) / $past(src_val[DW-1:0]) &&
         res_data[2*DW-1:DW] == $past(dst_val) % $past(src_val[DW-1:0]);
   endproperty
   a_div: assert property (p_div) else $error("quotient or remainder wrong");
   property p_ready; $fell(op_ready) |-> ##[1:9] op_ready; endproperty
   a_ready: assert property (p_ready) else $error("divide stalled too long");
   property p_ashr;
      tk && op_code == `CALU_OP_ASHR |=> res_data[DW-1:0] == {$past(db[DW-1]), $past(db[DW-1:1])}
         && flags_out[`CALU_FLG_C] == $past(db[0]);
   endproperty
   a_ashr: assert property (p_ashr) else $error("arithmetic right shift wrong");
   property p_rotate_left_through_carry;
      tk && op_code == `CALU_OP_ROTATE_LEFT_THROUGH_CARRY |=> res_data[DW-1:0] == {$past(db[DW-2:0]), $past(flags_in[`CALU_FLG_C])}
         && flags_out[`CALU_FLG_C] == $past(db[DW-1]);
   endproperty
   a_rotate_left_through_carry: assert property (p_rotate_left_through_carry) else $error("rotate through carry wrong");
endmodule // calu_core_sva

bind calu_core calu_core_sva #(.DW(DW)) u_sva (
   .clock(clock), .nrst(nrst), .ce(ce), .op_valid(op_valid), .op_code(op_code), .op_word(op_word),
   .op_use_imm(op_use_imm), .op_imm_two(op_imm_two), .dst_val(dst_val), .src_val(src_val),
   .imm_val(imm_val), .flags_in(flags_in), .op_ready(op_ready), .res_valid(res_valid),
   .res_data(res_data), .res_write(res_write), .res_word(res_word), .flags_out(flags_out),
   .op_illegal(op_illegal));

// ---- calu_core_tb.sv ----
// self-checking testbench for the arithmetic, logic and shift core
`timescale 1ns/1ps
`include "calu_consts.vh"
module calu_core_tb;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        ce = 1'b1;
   logic        op_valid = 1'b0;
   logic [4:0]  op_code = 5'h00;
   logic        op_word = 1'b0;
   logic        op_use_imm = 1'b0;
   logic        op_imm_two = 1'b0;
   logic [15:0] dst_val = 16'h0000;
   logic [15:0] src_val = 16'h0000;
   logic [7:0]  imm_val = 8'h00;
   logic        ld = 1'b0;
   logic [4:0]  ld_flags = 5'h00;
   logic [4:0]  flags_in, flags_out, g_flags;
   logic        op_ready, res_valid, res_write, res_word, op_illegal, g_write, g_ill, g_word;
   logic [15:0] res_data, g_data;
   int          errors = 0;
   int          tests_run = 0;
   int          waits;

   calu_core #(.DW(8)) DUT (
      .clock(clock), .nrst(nrst), .ce(ce), .op_valid(op_valid), .op_code(op_code), .op_word(op_word),
      .op_use_imm(op_use_imm), .op_imm_two(op_imm_two), .dst_val(dst_val), .src_val(src_val),
      .imm_val(imm_val), .flags_in(flags_in), .op_ready(op_ready), .res_valid(res_valid),
      .res_data(res_data), .res_write(res_write), .res_word(res_word), .flags_out(flags_out),
      .op_illegal(op_illegal));
   calu_flag_model u_flags (.clock(clock), .nrst(nrst), .ld(ld), .ld_flags(ld_flags),
      .res_valid(res_valid), .flags_out(flags_out), .flags_r(flags_in));

   initial begin
      forever #2 clock = ~clock;
   end

   ////////////////////////////////////////
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // preset flags, hold the op until ready, capture the answer pulse
   task automatic run(input logic [4:0] op, input logic w, im, input logic [15:0] d, s, input logic [4:0] f);
      @(posedge clock);
      ld <= 1'b1;
      ld_flags <= f;
      @(posedge clock);
      ld <= 1'b0;
      op_valid <= 1'b1;
      op_code <= op;
      op_word <= w;
      op_use_imm <= im;
      op_imm_two <= s[1];
      dst_val <= d;
      src_val <= s ^ {16{im}}; // register differs from immediate when im is set, so a wrong pick shows
      imm_val <= s[7:0];
      waits = 0;
      @(negedge clock);
      while (op_ready !== 1'b1 && waits <= 40) begin
         waits++;
         @(negedge clock);
      end
      if (waits > 40) begin
         errors++;
         $display("mismatch at %0t: op not accepted", $time);
      end
      // taken at this edge; the answer pulse stands for the next cycle only
      @(posedge clock);
      op_valid <= 1'b0;
      @(negedge clock);
      chk({15'h0, res_valid}, 16'h0001);
      g_data = res_data;
      g_word = res_word;
      g_flags = flags_out;
      g_write = res_write;
      g_ill = op_illegal;
   endtask

   // data, write strobe and masked {n,z,v,c}
   task automatic exp(input logic [4:0] op, input logic w, im, input logic [15:0] d, s, ed,
                      input logic [4:0] f, input logic [3:0] ef, input logic [3:0] m = 4'hF);
      run(op, w, im, d, s, f);
      if (op != `CALU_OP_CMP)
         chk(g_data, ed);
      chk({14'h0, g_write, g_ill}, {14'h0, op != `CALU_OP_CMP, 1'b0});
      chk({15'h0, g_word}, {15'h0, w || op == `CALU_OP_ADDS || op == `CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD ||
                                  op == `CALU_OP_MULU || op == `CALU_OP_DIVU});
      chk({12'h0, g_flags[3:0] & m}, {12'h0, ef & m});
   endtask

   task automatic rf(input logic [4:0] op, input logic w);
      run(op, w, 1'b1, 16'h0012, 16'h0034, 5'h15);
      chk({9'h0, g_write, g_ill, g_flags}, {9'h0, 1'b0, 1'b1, 5'h15});
      chk(g_data, 16'h0012);
   endtask

   ////////////////////////////////////////
   task automatic t_arith;
      exp(`CALU_OP_ADD, 0, 0, 16'h007F, 16'h0001, 16'h0080, 5'h00, 4'hA);
      exp(`CALU_OP_ADD, 0, 1, 16'hAB10, 16'h0022, 16'hAB32, 5'h00, 4'h0);
      exp(`CALU_OP_ADD, 1, 0, 16'hFFFF, 16'h0001, 16'h0000, 5'h00, 4'h5);
      exp(`CALU_OP_SUB, 1, 0, 16'h8000, 16'h0001, 16'h7FFF, 5'h00, 4'h2);
      exp(`CALU_OP_SUB, 0, 0, 16'h0000, 16'h0001, 16'h00FF, 5'h00, 4'h9);
      exp(`CALU_OP_ADD_CARRY, 0, 0, 16'h0010, 16'h0020, 16'h0031, 5'h01, 4'h0);
      exp(`CALU_OP_ADD_CARRY, 0, 1, 16'h00FF, 16'h0000, 16'h0000, 5'h01, 4'h1);
      exp(`CALU_OP_SUB_BORROW, 0, 0, 16'h0010, 16'h0001, 16'h000E, 5'h01, 4'h0);
      exp(`CALU_OP_SUB_BORROW, 0, 1, 16'h0000, 16'h0000, 16'h00FF, 5'h01, 4'h9);
   endtask

   task automatic t_step;
      exp(`CALU_OP_INC, 0, 0, 16'h00FF, 16'h0000, 16'h0000, 5'h01, 4'h5);
      exp(`CALU_OP_INC, 0, 0, 16'h007F, 16'h0000, 16'h0080, 5'h00, 4'hA);
      exp(`CALU_OP_DEC, 0, 0, 16'h0000, 16'h0000, 16'h00FF, 5'h00, 4'h8);
      exp(`CALU_OP_DEC, 0, 0, 16'h0080, 16'h0000, 16'h007F, 5'h00, 4'h2);
      exp(`CALU_OP_ADDS, 1, 0, 16'hFFFF, 16'h0002, 16'h0001, 5'h0A, 4'hA);
      exp(`CALU_OP_ADDS, 1, 0, 16'h1234, 16'h0001, 16'h1235, 5'h05, 4'h5);
      exp(`CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD, 1, 0, 16'h0000, 16'h0002, 16'hFFFE, 5'h00, 4'h0);
      exp(`CALU_OP_SUBTRACT_SMALL_CONSTANT_WORD, 1, 0, 16'h0001, 16'h0001, 16'h0000, 5'h00, 4'h0);
   endtask

   task automatic t_bcd_muldiv;
      exp(`CALU_OP_DADJ_ADD, 0, 0, 16'h009A, 16'h0000, 16'h0000, 5'h00, 4'h1, 4'h1);
      exp(`CALU_OP_DADJ_ADD, 0, 0, 16'h0012, 16'h0000, 16'h0018, 5'h10, 4'h0, 4'h1);
      exp(`CALU_OP_DADJ_SUB, 0, 0, 16'h000F, 16'h0000, 16'h0009, 5'h10, 4'h0, 4'h1);
      exp(`CALU_OP_DADJ_SUB, 0, 0, 16'h00F0, 16'h0000, 16'h0090, 5'h01, 4'h1, 4'h1);
      exp(`CALU_OP_MULU, 0, 0, 16'h00FF, 16'h00FF, 16'hFE01, 5'h05, 4'h5);
      exp(`CALU_OP_DIVU, 0, 0, 16'h1234, 16'h0056, 16'h1036, 5'h00, 4'h0, 4'hC);
      chk(16'(waits), 16'h0009);
      exp(`CALU_OP_DIVU, 0, 0, 16'h00FF, 16'h0001, 16'h00FF, 5'h00, 4'h8, 4'hC);
      exp(`CALU_OP_DIVU, 0, 0, 16'h1234, 16'h0000, 16'h1234, 5'h00, 4'h4, 4'h4);
   endtask

   task automatic t_cmp_refuse;
      exp(`CALU_OP_CMP, 0, 0, 16'h0005, 16'h0005, 16'h0000, 5'h00, 4'h4);
      exp(`CALU_OP_CMP, 0, 1, 16'h0005, 16'h0007, 16'h0000, 5'h00, 4'h9);
      exp(`CALU_OP_CMP, 1, 0, 16'h8000, 16'h0001, 16'h0000, 5'h00, 4'h2);
      rf(`CALU_OP_SUB, 0);
      rf(`CALU_OP_ADD, 1);
      rf(`CALU_OP_SUB, 1);
      rf(`CALU_OP_CMP, 1);
      rf(5'h1F, 0);
   endtask

   task automatic t_logic_shift;
      logic [7:0] lr[6] = '{8'h30, 8'hFC, 8'hCC, 8'h00, 8'hFF, 8'hFF};
      logic [7:0] sr[8] = '{8'h02, 8'hC0, 8'h02, 8'h40, 8'h03, 8'hC0, 8'h02, 8'h40};
      exp(`CALU_OP_NEG, 0, 0, 16'h0001, 16'h0000, 16'h00FF, 5'h00, 4'h9);
      exp(`CALU_OP_NEG, 0, 0, 16'h0080, 16'h0000, 16'h0080, 5'h00, 4'hB);
      exp(`CALU_OP_NOT, 0, 0, 16'h005A, 16'h0000, 16'h00A5, 5'h02, 4'h8, 4'hE);
      for (int i = 0; i < 6; i++) begin
         exp(5'(`CALU_OP_AND + i % 3), 0, i > 2, 16'h00F0, i > 2 ? 16'h000F : 16'h003C, {8'h00, lr[i]},
             5'h02, {lr[i][7], lr[i] == 8'h00, 2'b00}, 4'hE);
      end
      // 0x81 loses a one at either end, so carry is always set
      for (int i = 0; i < 8; i++) begin
         exp(5'(`CALU_OP_ASHL + i), 0, 0, 16'h0081, 16'h0000, {8'h00, sr[i]}, 5'h00, {sr[i][7], 3'b001});
      end
      exp(`CALU_OP_ROTATE_LEFT_THROUGH_CARRY, 0, 0, 16'h0000, 16'h0000, 16'h0001, 5'h01, 4'h0);
      exp(`CALU_OP_ROTATE_RIGHT_THROUGH_CARRY, 0, 0, 16'h0000, 16'h0000, 16'h0080, 5'h01, 4'h8);
   endtask

   // ce low freezes the core: an op presented then is not taken until ce returns
   task automatic t_freeze;
      @(posedge clock);
      ce <= 1'b0;
      op_valid <= 1'b1;
      op_code <= `CALU_OP_NOT;
      dst_val <= 16'h000F;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk({15'h0, res_valid}, 16'h0000);
      chk(res_data, 16'h0080);
      @(posedge clock);
      ce <= 1'b1;
      @(posedge clock);
      op_valid <= 1'b0;
      @(negedge clock);
      chk({15'h0, res_valid}, 16'h0001);
      chk(res_data, 16'h00F0);
   endtask

   ////////////////////////////////////////
   // reset for five edges, then every scenario in turn
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      chk({8'h00, res_valid, res_write, op_illegal, flags_out}, 16'h0000);
      chk(res_data, 16'h0000);
      t_arith;
      t_step;
      t_bcd_muldiv;
      t_cmp_refuse;
      t_logic_shift;
      t_freeze;
      tally_and_finish;
   end
endmodule // calu_core_tb

// ---- calu_divider.v ----
// sequential 16 by 8 unsigned restoring divider
`timescale 1ns/1ps
module calu_divider #(
   parameter DW = 8
) (
   clock,
   nrst,
   ce,
   start,
   dividend,
   divisor,
   busy,
   done,
   quotient,
   remainder,
   div_zero
);
   input  wire            clock;
   input  wire            nrst;
   input  wire            ce;
   input  wire            start;
   input  wire [2*DW-1:0] dividend;
   input  wire [DW-1:0]   divisor;
   output wire            busy;
   output reg             done;
   output reg  [DW-1:0]   quotient;
   output reg  [DW-1:0]   remainder;
   output reg             div_zero;

   reg  [DW:0]     rem_r;
   reg  [DW-1:0]   quo_r;
   reg  [DW-1:0]   dvs_r;
   reg  [3:0]      cnt_r;
   reg             run_r;
   wire [DW:0]     trial;
   wire [DW+1:0]   diff;

   assign busy  = run_r;
   // shift in next dividend bit then try subtracting
   assign trial = {rem_r[DW-1:0], quo_r[DW-1]};
   assign diff  = {1'b0, trial} - {2'b00, dvs_r};

   ////////////////////////////////////////////////////////////////////////
   // one quotient bit per enabled cycle; zero divisor skips the loop
   always @(posedge clock) begin
      if (!nrst) begin
         rem_r     <= {(DW+1){1'b0}};
         quo_r     <= {DW{1'b0}};
         dvs_r     <= {DW{1'b0}};
         cnt_r     <= 4'h0;
         run_r     <= 1'b0;
         done      <= 1'b0;
         quotient  <= {DW{1'b0}};
         remainder <= {DW{1'b0}};
         div_zero  <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start && !run_r) begin
            if (divisor == {DW{1'b0}}) begin
               done      <= 1'b1; // result undefined; operands left as is
               div_zero  <= 1'b1;
               quotient  <= dividend[DW-1:0];
               remainder <= dividend[2*DW-1:DW];
            end else begin
               rem_r    <= {1'b0, dividend[2*DW-1:DW]};
               quo_r    <= dividend[DW-1:0];
               dvs_r    <= divisor;
               cnt_r    <= `CALU_DIV_STEPS;
               run_r    <= 1'b1;
               div_zero <= 1'b0;
            end
         end else if (run_r) begin
            if (!diff[DW+1]) begin
               rem_r <= diff[DW:0];
               quo_r <= {quo_r[DW-2:0], 1'b1};
            end else begin
               rem_r <= trial;
               quo_r <= {quo_r[DW-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               run_r     <= 1'b0;
               done      <= 1'b1;
               quotient  <= !diff[DW+1] ? {quo_r[DW-2:0], 1'b1} : {quo_r[DW-2:0], 1'b0};
               remainder <= !diff[DW+1] ? diff[DW-1:0] : trial[DW-1:0];
            end
         end
      end
   end
endmodule // calu_divider

// ---- calu_flag_model.sv ----
// behavioural model of the cpu condition flags register feeding the core
`timescale 1ns/1ps
module calu_flag_model (
   input  wire        clock,
   input  wire        nrst,
   input  wire        ld,
   input  wire [4:0]  ld_flags,
   input  wire        res_valid,
   input  wire [4:0]  flags_out,
   output logic [4:0] flags_r
);
   // a preset wins over a result so a scenario can force the carry
   always @(posedge clock) begin
      if (!nrst)
         flags_r <= 5'h00;
      else if (ld)
         flags_r <= ld_flags;
      else if (res_valid)
         flags_r <= flags_out;
   end
endmodule // calu_flag_model
